// >>> crt_pkg.sv
// Shared constants, register layout and types for the capture/reload timer.
package crt_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] CRT_IDX_TIMER_CONTROL = 8'hc8;
    localparam logic [7:0] CRT_IDX_MODE_OPTIONS  = 8'hc9;
    localparam logic [7:0] CRT_IDX_CAPTURE_LOW   = 8'hca;
    localparam logic [7:0] CRT_IDX_CAPTURE_HIGH  = 8'hcb;
    localparam logic [7:0] CRT_IDX_COUNT_LOW     = 8'hcc;
    localparam logic [7:0] CRT_IDX_COUNT_HIGH    = 8'hcd;
    localparam logic [7:0] CRT_IDX_CLOCK_MODE    = 8'hce;

    // Bus widths.
    localparam int CRT_AW = 12;
    localparam int CRT_DW = 32;

    // Field positions in timer_control.
    localparam int CRT_CTL_OVERFLOW_FLAG  = 7;
    localparam int CRT_CTL_EXTERNAL_FLAG  = 6;
    localparam int CRT_CTL_RX_CLOCK_SEL   = 5;
    localparam int CRT_CTL_TX_CLOCK_SEL   = 4;
    localparam int CRT_CTL_TRIGGER_ENABLE = 3;
    localparam int CRT_CTL_RUN            = 2;
    localparam int CRT_CTL_COUNT_SOURCE   = 1;
    localparam int CRT_CTL_CAPTURE_SEL    = 0;

    // Field positions in timer_mode_options and clock_mode.
    localparam int CRT_MOD_CLOCK_OUT_EN = 1;
    localparam int CRT_MOD_DOWN_COUNT   = 0;
    localparam int CRT_CLK_SIX_CLOCK    = 0;

    // Reset values.
    localparam logic [7:0] CRT_RST_CONTROL = 8'h00;
    localparam logic [1:0] CRT_RST_OPTIONS = 2'h0;
    localparam logic [7:0] CRT_RST_BYTE    = 8'h00;

    // Timing counts in oscillator (pclk) cycles.
    localparam logic [3:0] CRT_TWELVE_CLOCK_LAST = 4'hb;
    localparam logic [3:0] CRT_SIX_CLOCK_LAST    = 4'h5;
    localparam logic [15:0] CRT_COUNT_TOP        = 16'hffff;

    // Control register as a packed struct, bit 7 first.
    typedef struct packed {
        logic overflow_flag;
        logic external_event_flag;
        logic serial_rx_clock_select;
        logic serial_tx_clock_select;
        logic external_trigger_enable;
        logic run_control;
        logic count_source_select;
        logic capture_reload_select;
    } crt_ctrl_s;

    // Bus slave sequencing states.
    typedef enum logic [2:0] {
        CRT_BUS_IDLE = 3'h1,
        CRT_BUS_WAIT = 3'h2,
        CRT_BUS_DONE = 3'h4
    } crt_bus_e;

endpackage : crt_pkg

// >>> crt_tick_gen.sv
// Machine-cycle and half-rate enable pulses derived from the oscillator.
`timescale 1ns/1ps
module crt_tick_gen (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Rate select.
    input  wire logic six_clock_mode,
    // Enable pulses.
    output logic      machine_tick,
    output logic      half_tick
);
    import crt_pkg::*;

    logic [3:0] phase_r;
    logic       half_r;
    logic [3:0] last;

    assign last         = six_clock_mode ? CRT_SIX_CLOCK_LAST
                                         : CRT_TWELVE_CLOCK_LAST;
    assign machine_tick = (phase_r == last);
    assign half_tick    = half_r;

    // Phase counter; a mode change mid-cycle keeps the phase, which wraps to zero once it reaches or passes the new last value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= 4'h0;
        end else if (phase_r >= last) begin
            phase_r <= 4'h0;
        end else begin
            phase_r <= phase_r + 4'h1;
        end
    end

    // Half-rate pulse for clock-out and baud operation.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_r <= 1'b0;
        end else begin
            half_r <= ~half_r;
        end
    end

endmodule : crt_tick_gen

// >>> crt_edge_sampler.sv
// Pin synchroniser with once-per-tick sampling and falling-edge detect.
`timescale 1ns/1ps
module crt_edge_sampler (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin and sample strobe.
    input  wire logic pin,
    input  wire logic sample_tick,
    // Results.
    output logic      level,
    output logic      fell
);
    logic sync1_r;
    logic sync2_r;
    logic sample_r;
    logic fell_r;

    assign level = sample_r;
    assign fell  = fell_r;

    // Two flops before anything looks at the pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
        end
    end

    // High in one sample and low in the next marks a falling edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_r <= 1'b0;
            fell_r   <= 1'b0;
        end else if (sample_tick) begin
            sample_r <= sync2_r;
            fell_r   <= sample_r & ~sync2_r;
        end else begin
            fell_r   <= 1'b0;
        end
    end

endmodule : crt_edge_sampler

// >>> crt_timer.sv
// Sixteen-bit capture/reload timer with APB register access.
`timescale 1ns/1ps
// Overview of operation
// - Timer function counts once per machine cycle, twelve or six clocks.
// - Event function samples the count pin per machine cycle; high then low counts.
// - Counted event appears one machine cycle after the edge is seen.
// - Off without run; serial select gives baud; else capture or reload.
// - Capture mode counts up and sets the overflow flag on overflow.
// - Trigger falling edge copies the count into capture bytes, sets event flag.
// - Reset clears down counting so the timer counts up.
// - Reload mode counts to FFFF, sets overflow flag, reloads capture value.
// - With trigger enabled a trigger falling edge also reloads, sets event flag.
// - Down enabled with trigger high counts up, overflows and reloads.
// - Down enabled with trigger low counts down; at capture value reloads FFFF.
// - In up/down mode the event flag toggles per wrap and raises no request.
// - Clock source cleared and clock output enabled gives square wave on pin.
// - Clock output rate is oscillator over four times (65536 minus capture).
// - Clock output rollovers raise no interrupt.
// - Baud generation and clock output may run together from one capture value.
// - Counting only while run is set, clock output included.
// - With down counting disabled both flags are interrupt sources.
// - Serial clock selects suppress the overflow flag.
// - Serial clock selects route overflow pulses to receive or transmit clock.
// - Serial clock selects force reload and ignore trigger events.
module crt_timer (
    // Clock and reset.
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB slave.
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [crt_pkg::CRT_AW-1:0] paddr,
    input  wire logic [crt_pkg::CRT_DW-1:0] pwdata,
    input  wire logic [3:0]               pstrb,
    output logic [crt_pkg::CRT_DW-1:0]    prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Pins.
    input  wire logic                     event_count_input,
    input  wire logic                     trigger_direction_input,
    output logic                          clock_output_pin_o,
    output logic                          clock_output_pin_oe,
    // Serial port clocks and interrupt source.
    output logic                          serial_rx_clock_pulse,
    output logic                          serial_tx_clock_pulse,
    output logic                          timer_irq_source
);
    import crt_pkg::*;

    // Register state.
    crt_ctrl_s    ctrl_r;
    logic         clock_output_enable_r;
    logic         down_count_enable_r;
    logic         six_clock_mode_r;
    logic [15:0]  capture_r;
    logic [15:0]  count_r;
    logic         event_pending_r;
    logic         pin_level_r;

    // Bus state, serial clock pulse and interrupt flops.
    crt_bus_e                  bus_r;
    logic [CRT_DW-1:0]         prdata_r;
    logic                      pslverr_r;
    logic                      rx_pulse_r;
    logic                      tx_pulse_r;
    logic                      irq_r;

    // Tick and pin sampler outputs.
    logic machine_tick;
    logic half_tick;
    logic event_level;
    logic event_fell;
    logic trig_level;
    logic trig_fell;

    // Index decode; returns 1 when the byte address matches the index.
    function automatic logic hit(input logic [CRT_AW-1:0] a,
                                 input logic [7:0]        idx);
        hit = (a == {2'h0, idx, 2'h0});
    endfunction : hit

    // Whole-register decode, used for write qualify and error.
    function automatic logic mapped(input logic [CRT_AW-1:0] a);
        mapped = hit(a, CRT_IDX_TIMER_CONTROL) | hit(a, CRT_IDX_MODE_OPTIONS)
               | hit(a, CRT_IDX_CAPTURE_LOW)   | hit(a, CRT_IDX_CAPTURE_HIGH)
               | hit(a, CRT_IDX_COUNT_LOW)     | hit(a, CRT_IDX_COUNT_HIGH)
               | hit(a, CRT_IDX_CLOCK_MODE);
    endfunction : mapped

    // Shared divider for machine cycles and the half-rate clock.
    crt_tick_gen u_tick (
        .pclk           (pclk),
        .presetn        (presetn),
        .six_clock_mode (six_clock_mode_r),
        .machine_tick   (machine_tick),
        .half_tick      (half_tick)
    );

    // Event count pin, sampled once per machine cycle.
    crt_edge_sampler u_event (
        .pclk        (pclk),
        .presetn     (presetn),
        .pin         (event_count_input),
        .sample_tick (machine_tick),
        .level       (event_level),
        .fell        (event_fell)
    );

    // Trigger/direction pin, sampled the same way.
    crt_edge_sampler u_trig (
        .pclk        (pclk),
        .presetn     (presetn),
        .pin         (trigger_direction_input),
        .sample_tick (machine_tick),
        .level       (trig_level),
        .fell        (trig_fell)
    );

    // Mode decode.
    logic baud_mode;
    logic clkout_mode;
    logic capture_mode;
    logic updown_mode;
    logic fast_rate;
    logic count_tick;
    logic counting_down;
    logic at_top;
    logic at_floor;
    logic wrap_up;
    logic wrap_down;
    logic wrap;
    logic trig_event;

    assign baud_mode    = ctrl_r.serial_rx_clock_select
                        | ctrl_r.serial_tx_clock_select;
    assign clkout_mode  = clock_output_enable_r
                        & ~ctrl_r.count_source_select;
    // Serial selects override the capture choice.
    assign capture_mode = ~baud_mode & ~clkout_mode
                        & ctrl_r.capture_reload_select;
    assign updown_mode  = down_count_enable_r & ~capture_mode & ~baud_mode;
    // Clock out, and baud with the count source cleared, count at half the
    // oscillator, which gives the divide-by-four square wave after the pin toggle.
    assign fast_rate    = (baud_mode | clkout_mode)
                        & ~ctrl_r.count_source_select;
    // Event counts land one machine cycle after the edge is seen.
    assign count_tick   = ctrl_r.run_control & (
                          ctrl_r.count_source_select
                              ? (machine_tick & event_pending_r)
                              : (fast_rate ? half_tick
                                           : machine_tick));
    assign counting_down = updown_mode & ~trig_level;
    assign at_top    = (count_r == CRT_COUNT_TOP);
    assign at_floor  = (count_r == capture_r);
    assign wrap_up   = count_tick & ~counting_down & at_top;
    assign wrap_down = count_tick & counting_down & at_floor;
    assign wrap      = wrap_up | wrap_down;
    // Trigger edges are ignored in baud, up/down and clock-out use.
    assign trig_event = ctrl_r.run_control & trig_fell
                      & ctrl_r.external_trigger_enable & ~clkout_mode
                      & ~baud_mode & ~updown_mode;

    // Bus access qualifiers; a write lands on the edge that ends the access.
    logic acc;
    logic wr;
    assign acc = psel & penable & (bus_r == CRT_BUS_DONE);
    assign wr  = acc & pwrite & pstrb[0] & mapped(paddr);

    // Pending event: the edge is remembered until the next machine cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_pending_r <= 1'b0;
        end else if (machine_tick) begin
            event_pending_r <= event_fell;
        end else if (event_fell) begin
            event_pending_r <= 1'b1;
        end
    end

    // Count register: software writes win, then hardware updates.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= {CRT_RST_BYTE, CRT_RST_BYTE};
        end else if (wr && hit(paddr, CRT_IDX_COUNT_LOW)) begin
            count_r[7:0] <= pwdata[7:0];
        end else if (wr && hit(paddr, CRT_IDX_COUNT_HIGH)) begin
            count_r[15:8] <= pwdata[7:0];
        end else if (trig_event && !capture_mode) begin
            count_r <= capture_r;
        end else if (wrap_down) begin
            count_r <= CRT_COUNT_TOP;
        end else if (wrap_up && !capture_mode) begin
            // Reload mode, up/down upward, baud and clock out reload.
            count_r <= capture_r;
        end else if (count_tick && counting_down) begin
            count_r <= count_r - 16'h0001;
        end else if (count_tick) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // Capture/reload bytes: written by software, loaded by trigger capture.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_r <= {CRT_RST_BYTE, CRT_RST_BYTE};
        end else if (wr && hit(paddr, CRT_IDX_CAPTURE_LOW)) begin
            capture_r[7:0] <= pwdata[7:0];
        end else if (wr && hit(paddr, CRT_IDX_CAPTURE_HIGH)) begin
            capture_r[15:8] <= pwdata[7:0];
        end else if (trig_event && capture_mode) begin
            capture_r <= count_r;
        end
    end

    // Control bits other than the flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r.serial_rx_clock_select  <= CRT_RST_CONTROL[5];
            ctrl_r.serial_tx_clock_select  <= CRT_RST_CONTROL[4];
            ctrl_r.external_trigger_enable <= CRT_RST_CONTROL[3];
            ctrl_r.run_control             <= CRT_RST_CONTROL[2];
            ctrl_r.count_source_select     <= CRT_RST_CONTROL[1];
            ctrl_r.capture_reload_select   <= CRT_RST_CONTROL[0];
        end else if (wr && hit(paddr, CRT_IDX_TIMER_CONTROL)) begin
            ctrl_r.serial_rx_clock_select  <= pwdata[CRT_CTL_RX_CLOCK_SEL];
            ctrl_r.serial_tx_clock_select  <= pwdata[CRT_CTL_TX_CLOCK_SEL];
            ctrl_r.external_trigger_enable <= pwdata[CRT_CTL_TRIGGER_ENABLE];
            ctrl_r.run_control             <= pwdata[CRT_CTL_RUN];
            ctrl_r.count_source_select     <= pwdata[CRT_CTL_COUNT_SOURCE];
            ctrl_r.capture_reload_select   <= pwdata[CRT_CTL_CAPTURE_SEL];
        end
    end

    // Overflow flag: hardware set beats a software clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r.overflow_flag <= CRT_RST_CONTROL[7];
        end else if (wrap && !baud_mode && !clkout_mode) begin
            ctrl_r.overflow_flag <= 1'b1;
        end else if (wr && hit(paddr, CRT_IDX_TIMER_CONTROL)) begin
            ctrl_r.overflow_flag <= pwdata[CRT_CTL_OVERFLOW_FLAG];
        end
    end

    // External event flag: set by trigger events, toggled in up/down mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r.external_event_flag <= CRT_RST_CONTROL[6];
        end else if (updown_mode && wrap) begin
            ctrl_r.external_event_flag <= ~ctrl_r.external_event_flag;
        end else if (trig_event) begin
            ctrl_r.external_event_flag <= 1'b1;
        end else if (wr && hit(paddr, CRT_IDX_TIMER_CONTROL)) begin
            ctrl_r.external_event_flag <= pwdata[CRT_CTL_EXTERNAL_FLAG];
        end
    end

    // Mode options and the rate select; down counting resets to zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_output_enable_r <= CRT_RST_OPTIONS[1];
            down_count_enable_r   <= CRT_RST_OPTIONS[0];
            six_clock_mode_r      <= 1'b0;
        end else if (wr && hit(paddr, CRT_IDX_MODE_OPTIONS)) begin
            clock_output_enable_r <= pwdata[CRT_MOD_CLOCK_OUT_EN];
            down_count_enable_r   <= pwdata[CRT_MOD_DOWN_COUNT];
        end else if (wr && hit(paddr, CRT_IDX_CLOCK_MODE)) begin
            six_clock_mode_r      <= pwdata[CRT_CLK_SIX_CLOCK];
        end
    end

    // Square wave: the pin toggles on each rollover, so it holds still
    // whenever run is cleared.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_level_r <= 1'b0;
        end else if (clkout_mode && wrap_up) begin
            pin_level_r <= ~pin_level_r;
        end
    end

    // Pin drive and enable come from flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_output_pin_o  <= 1'b0;
            clock_output_pin_oe <= 1'b0;
        end else begin
            clock_output_pin_o  <= pin_level_r;
            clock_output_pin_oe <= clkout_mode;
        end
    end

    // Serial clock pulses: one pclk wide per rollover, per direction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pulse_r <= 1'b0;
            tx_pulse_r <= 1'b0;
        end else begin
            rx_pulse_r <= wrap_up & ctrl_r.serial_rx_clock_select;
            tx_pulse_r <= wrap_up & ctrl_r.serial_tx_clock_select;
        end
    end

    // Interrupt source level; the event flag is masked in up/down use.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= ctrl_r.overflow_flag
                   | (ctrl_r.external_event_flag & ~down_count_enable_r);
        end
    end

    assign serial_rx_clock_pulse = rx_pulse_r;
    assign serial_tx_clock_pulse = tx_pulse_r;
    assign timer_irq_source      = irq_r;

    // Bus sequencing: two wait cycles so read data can come from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_r <= CRT_BUS_IDLE;
        end else begin
            case (bus_r)
                CRT_BUS_IDLE: begin
                    if (psel && penable) begin
                        bus_r <= CRT_BUS_WAIT;
                    end
                end
                CRT_BUS_WAIT: begin
                    bus_r <= CRT_BUS_DONE;
                end
                CRT_BUS_DONE: begin
                    bus_r <= CRT_BUS_IDLE;
                end
                default: begin
                    bus_r <= CRT_BUS_IDLE;
                end
            endcase
        end
    end

    // Read mux, latched while the answer is being prepared.
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit(paddr, CRT_IDX_TIMER_CONTROL)) begin
            rd_byte = ctrl_r;
        end else if (hit(paddr, CRT_IDX_MODE_OPTIONS)) begin
            rd_byte = {6'h00, clock_output_enable_r, down_count_enable_r};
        end else if (hit(paddr, CRT_IDX_CAPTURE_LOW)) begin
            rd_byte = capture_r[7:0];
        end else if (hit(paddr, CRT_IDX_CAPTURE_HIGH)) begin
            rd_byte = capture_r[15:8];
        end else if (hit(paddr, CRT_IDX_COUNT_LOW)) begin
            rd_byte = count_r[7:0];
        end else if (hit(paddr, CRT_IDX_COUNT_HIGH)) begin
            rd_byte = count_r[15:8];
        end else if (hit(paddr, CRT_IDX_CLOCK_MODE)) begin
            rd_byte = {7'h00, six_clock_mode_r};
        end
    end

    // Answer registers: error and read data for the done cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end else if (bus_r == CRT_BUS_WAIT) begin
            prdata_r  <= {24'h000000, rd_byte};
            pslverr_r <= ~mapped(paddr);
        end else begin
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end
    end

    // Ready is high exactly in the done cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= (bus_r == CRT_BUS_WAIT);
        end
    end

    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    // The count pin level is only used through its edges; the level
    // output of that sampler stays unused on purpose.
    logic unused_level;
    assign unused_level = event_level;

endmodule : crt_timer

// >>> crt_timer_asserts.sv
// Port-level checks for the capture/reload timer.
`timescale 1ns/1ps
module crt_timer_asserts (
    // Clock, reset and bus answer.
    input wire logic        pclk, presetn, psel, penable, pready, pslverr,
    input wire logic [31:0] prdata,
    // Pins and serial clocks.
    input wire logic        clock_output_pin_o, clock_output_pin_oe,
    input wire logic        serial_rx_clock_pulse, serial_tx_clock_pulse
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // The slave always inserts two wait states.
    sequence wait2_s;
        !pready ##1 !pready ##1 pready;
    endsequence
    AST_PREADY_WAIT: assert property ($rose(penable) && psel |-> wait2_s)
        else $error("pready not on third access cycle");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    AST_TX_ONE: assert property (serial_tx_clock_pulse |=> !serial_tx_clock_pulse)
        else $error("tx clock pulse too long");
    AST_RX_ONE: assert property (serial_rx_clock_pulse |=> !serial_rx_clock_pulse)
        else $error("rx clock pulse too long");
    AST_PIN_DRIVEN: assert property ($changed(clock_output_pin_o) |-> clock_output_pin_oe || $past(clock_output_pin_oe))
        else $error("clock pin moved while not driven");
    AST_HALF_PERIOD: assert property ($changed(clock_output_pin_o) |=> $stable(clock_output_pin_o))
        else $error("clock pin half period below two cycles");
endmodule : crt_timer_asserts

// >>> crt_pin_model.sv
// Outside source for the count and trigger pins.
`timescale 1ns/1ps
module crt_pin_model (
    // Clock.
    input wire logic pclk,
    // Pins toward the timer.
    output logic     event_count_input,
    output logic     trigger_direction_input
);
    // Both pins idle high.
    initial begin
        event_count_input = 1'b1;
        trigger_direction_input = 1'b1;
    end
    // Each level is held two machine cycles so no sample misses it.
    task automatic pulse(input bit trig, input int n);
        repeat (n) begin
            repeat (24) @(posedge pclk);
            if (trig) trigger_direction_input <= 1'b0; else event_count_input <= 1'b0;
            repeat (24) @(posedge pclk);
            if (trig) trigger_direction_input <= 1'b1; else event_count_input <= 1'b1;
        end
    endtask : pulse
endmodule : crt_pin_model

// >>> capture_reload_timer_tb.sv
// Self-checking bench for the capture/reload timer.
`timescale 1ns/1ps
module capture_reload_timer_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        pin_o, pin_oe, pin_q, rxp, txp, irq, evt, trg;
    int          bad_count, checks, ntx, ntog, a, b, m;
    crt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_count_input(evt), .trigger_direction_input(trg), .clock_output_pin_o(pin_o), .clock_output_pin_oe(pin_oe), .serial_rx_clock_pulse(rxp), .serial_tx_clock_pulse(txp), .timer_irq_source(irq));
    crt_pin_model pm (.pclk(pclk), .event_count_input(evt), .trigger_direction_input(trg));
    // Running tallies of paired tx/rx pulses and clock pin edges.
    always @(posedge pclk) begin
        pin_q <= pin_o;
        ntx <= ntx + int'(txp & rxp);
        ntog <= ntog + int'(pin_o !== pin_q);
    end
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic cmp(input logic [31:0] got, input int lo, input int hi);
        checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : cmp
    // Whole APB transfer; read data is taken at the edge that sees pready.
    task automatic xfer(input bit w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        psel <= 1'b1; pwrite <= w; paddr <= {2'h0, idx, 2'h0}; pwdata <= {24'h0, d};
        @(posedge pclk); penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin bad_count++; close_out(); end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input int lo, input int hi);
        xfer(1'b0, idx, 8'h00);
        cmp(rd, lo, hi);
    endtask : rdc
    task automatic close_out;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Main sequence of tests.
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0; pstrb = 4'hf; ntx = 0; ntog = 0;
        pin_q = 1'b0; bad_count = 0; checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (m = 0; m < 6; m++) rdc(8'hc8 + 8'(m), 0, 0);
        xfer(1'b0, 8'hd0, 8'h00); cmp({31'h0, err}, 1, 1);
        $display("test reset and map done");
        for (m = 0; m < 2; m++) begin
            wr(8'hce, 8'(m)); wr(8'hcc, 8'h00); wr(8'hcd, 8'h00); wr(8'hc8, 8'h04);
            repeat (120) @(posedge pclk);
            wr(8'hc8, 8'h00); rdc(8'hcc, 120 / (12 - 6 * m), 120 / (12 - 6 * m) + 2);
        end
        wr(8'hce, 8'h00); wr(8'hcc, 8'h00); wr(8'hc8, 8'h06); pm.pulse(1'b0, 5);
        repeat (48) @(posedge pclk);
        wr(8'hc8, 8'h00); rdc(8'hcc, 5, 5);
        wr(8'hcc, 8'h00); wr(8'hc8, 8'h0d); pm.pulse(1'b1, 1);
        rdc(8'hc8, 8'h4d, 8'h4d); wr(8'hc8, 8'h04);
        rdc(8'hc8, 8'h04, 8'h04); rdc(8'hca, 1, 8);
        $display("test rate, events and capture done");
        wr(8'hca, 8'h34); wr(8'hcb, 8'h12); wr(8'hcc, 8'hf8); wr(8'hcd, 8'hff); wr(8'hc8, 8'h04);
        repeat (144) @(posedge pclk);
        rdc(8'hc8, 8'h84, 8'h84); rdc(8'hcd, 8'h12, 8'h12);
        cmp({31'h0, irq}, 1, 1); wr(8'hc8, 8'h00);
        wr(8'hc9, 8'h01); wr(8'hca, 8'h00); wr(8'hcb, 8'h00); wr(8'hcc, 8'h03); wr(8'hcd, 8'h00);
        pm.trigger_direction_input <= 1'b0;
        wr(8'hc8, 8'h04); repeat (72) @(posedge pclk);
        rdc(8'hc8, 8'hc4, 8'hc4);
        wr(8'hc8, 8'h00); rdc(8'hc8, 0, 0);
        $display("test reload and down count done");
        pm.trigger_direction_input <= 1'b1;
        wr(8'hc9, 8'h02); wr(8'hca, 8'hf0); wr(8'hcb, 8'hff); wr(8'hc8, 8'h04);
        a = ntog; repeat (640) @(posedge pclk);
        cmp(ntog - a, 19, 21); cmp({31'h0, pin_oe}, 1, 1);
        wr(8'hc8, 8'h34); a = ntx; b = ntog; repeat (640) @(posedge pclk);
        cmp(ntx - a, 19, 21);
        cmp(ntog - b, 19, 21); rdc(8'hc8, 8'h34, 8'h34);
        wr(8'hc8, 8'h00); a = ntog; repeat (200) @(posedge pclk);
        cmp(ntog - a, 0, 1);
        $display("test clock out and baud done");
        close_out();
    end
endmodule : capture_reload_timer_tb
bind crt_timer crt_timer_asserts u_chk (.*);
